// File: lce_pkg.sv
// Package for the ladder contact and coil element block.
// Shared reset values and tag write encodings.
package lce_pkg;
    localparam logic RESET_HIST  = 1'h0;
    localparam logic RESET_RUNG  = 1'h0;
    localparam logic RESET_WR    = 1'h0;
    localparam logic TAG_ON      = 1'h1;
    localparam logic TAG_OFF     = 1'h0;
endpackage

// File: lce_ladder_elements.sv
// Ladder relay and coil elements, one evaluation per scan strobe.
// Assumes the scan sequencer pulses SCAN for one SYS_CLK cycle per scan and
// holds rung inputs and tag values stable around that pulse.
// Function
// - Open contact passes rung when tag is 1
// - Closed contact passes rung when tag is 0
// - Contacts resample tag every scan
// - Rise relay passes on tag 0 to 1
// - Edge relays pass exactly one scan only
// - Fall relay passes on tag 1 to 0
// - Coils copy rung input to output
// - Direct coil writes rung state to tag
// - Inverted coil writes inverse rung state
// - Direct and inverted coils write every scan
// - Latch set coil writes 1 when on
// - Latch set coil untouched when off
// - Latch set only when tag reads 0
// - Latch clear coil writes 0 when off
// - Latch clear coil untouched when on
// - Latch clear only when tag reads 1
`timescale 1ns/1ps
`default_nettype none

module lce_contact
    import lce_pkg::*;
#(
    parameter logic PASS_LEVEL = TAG_ON
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic scan,
    input  wire logic rung_in,
    input  wire logic tag,
    output var  logic rung_out
);

    typedef struct packed {
        logic rung_out;
    } lce_contact_st_t;

    localparam lce_contact_st_t CONTACT_RESET = '{
        rung_out: RESET_RUNG
    };

    lce_contact_st_t st_r;
    lce_contact_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (scan) begin
            st_nxt.rung_out = rung_in & (tag == PASS_LEVEL);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= CONTACT_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rung_out = st_r.rung_out;

endmodule // lce_contact

module lce_edge_relay
    import lce_pkg::*;
#(
    parameter logic FIRE_LEVEL = TAG_ON
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic scan,
    input  wire logic rung_in,
    input  wire logic tag,
    output var  logic rung_out
);

    typedef struct packed {
        logic hist;
        logic rung_out;
    } lce_edge_st_t;

    localparam lce_edge_st_t EDGE_RESET = '{
        hist:     RESET_HIST,
        rung_out: RESET_RUNG
    };

    lce_edge_st_t st_r;
    lce_edge_st_t st_nxt;

    // History follows the tag on every scan, whatever the rung
    always_comb begin
        st_nxt = st_r;
        if (scan) begin
            st_nxt.rung_out = rung_in & (tag == FIRE_LEVEL)
                            & (st_r.hist != FIRE_LEVEL);
            st_nxt.hist     = tag;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= EDGE_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rung_out = st_r.rung_out;

endmodule // lce_edge_relay

module lce_level_coil
    import lce_pkg::*;
#(
    parameter logic ON_LEVEL = TAG_ON
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic scan,
    input  wire logic rung_in,
    output var  logic rung_out,
    output var  logic tag_we,
    output var  logic tag_wd
);

    typedef struct packed {
        logic rung_out;
        logic tag_we;
        logic tag_wd;
    } lce_level_st_t;

    localparam lce_level_st_t LEVEL_RESET = '{
        rung_out: RESET_RUNG,
        tag_we:   RESET_WR,
        tag_wd:   RESET_WR
    };

    lce_level_st_t st_r;
    lce_level_st_t st_nxt;

    // Strobe lasts one cycle; every scan rewrites the tag
    always_comb begin
        st_nxt        = st_r;
        st_nxt.tag_we = 1'h0;
        if (scan) begin
            st_nxt.rung_out = rung_in;
            st_nxt.tag_we   = 1'h1;
            st_nxt.tag_wd   = rung_in ? ON_LEVEL : ~ON_LEVEL;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= LEVEL_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rung_out = st_r.rung_out;
    assign tag_we   = st_r.tag_we;
    assign tag_wd   = st_r.tag_wd;

endmodule // lce_level_coil

module lce_latch_coil
    import lce_pkg::*;
#(
    parameter logic ACT_RUNG    = 1'h1,
    parameter logic LATCH_LEVEL = TAG_ON
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic scan,
    input  wire logic rung_in,
    input  wire logic tag,
    output var  logic rung_out,
    output var  logic tag_we,
    output var  logic tag_wd
);

    typedef struct packed {
        logic rung_out;
        logic tag_we;
        logic tag_wd;
    } lce_latch_st_t;

    localparam lce_latch_st_t LATCH_RESET = '{
        rung_out: RESET_RUNG,
        tag_we:   RESET_WR,
        tag_wd:   RESET_WR
    };

    lce_latch_st_t st_r;
    lce_latch_st_t st_nxt;

    // Write only when the tag would actually change
    always_comb begin
        st_nxt        = st_r;
        st_nxt.tag_we = 1'h0;
        if (scan) begin
            st_nxt.rung_out = rung_in;
            st_nxt.tag_we   = (rung_in == ACT_RUNG)
                            & (tag != LATCH_LEVEL);
            st_nxt.tag_wd   = LATCH_LEVEL;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= LATCH_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rung_out = st_r.rung_out;
    assign tag_we   = st_r.tag_we;
    assign tag_wd   = st_r.tag_wd;

endmodule // lce_latch_coil

module lce_ladder_elements
    import lce_pkg::*;
(
    input  wire logic SYS_CLK,
    input  wire logic RESET_N,
    input  wire logic SCAN,
    input  wire logic OPEN_RUNG_IN,
    input  wire logic OPEN_TAG,
    output var  logic OPEN_RUNG_OUT,
    input  wire logic CLOSED_RUNG_IN,
    input  wire logic CLOSED_TAG,
    output var  logic CLOSED_RUNG_OUT,
    input  wire logic RISE_RUNG_IN,
    input  wire logic RISE_TAG,
    output var  logic RISE_RUNG_OUT,
    input  wire logic FALL_RUNG_IN,
    input  wire logic FALL_TAG,
    output var  logic FALL_RUNG_OUT,
    input  wire logic DIRECT_RUNG_IN,
    output var  logic DIRECT_RUNG_OUT,
    output var  logic DIRECT_TAG_WE,
    output var  logic DIRECT_TAG_WD,
    input  wire logic INV_RUNG_IN,
    output var  logic INV_RUNG_OUT,
    output var  logic INV_TAG_WE,
    output var  logic INV_TAG_WD,
    input  wire logic SET_RUNG_IN,
    input  wire logic SET_TAG,
    output var  logic SET_RUNG_OUT,
    output var  logic SET_TAG_WE,
    output var  logic SET_TAG_WD,
    input  wire logic CLR_RUNG_IN,
    input  wire logic CLR_TAG,
    output var  logic CLR_RUNG_OUT,
    output var  logic CLR_TAG_WE,
    output var  logic CLR_TAG_WD
);

    lce_contact #(
        .PASS_LEVEL (TAG_ON)
    ) open_contact_inst (
        .clk      (SYS_CLK),
        .rst_n    (RESET_N),
        .scan     (SCAN),
        .rung_in  (OPEN_RUNG_IN),
        .tag      (OPEN_TAG),
        .rung_out (OPEN_RUNG_OUT)
    );

    lce_contact #(
        .PASS_LEVEL (TAG_OFF)
    ) closed_contact_inst (
        .clk      (SYS_CLK),
        .rst_n    (RESET_N),
        .scan     (SCAN),
        .rung_in  (CLOSED_RUNG_IN),
        .tag      (CLOSED_TAG),
        .rung_out (CLOSED_RUNG_OUT)
    );

    lce_edge_relay #(
        .FIRE_LEVEL (TAG_ON)
    ) rise_edge_relay_inst (
        .clk      (SYS_CLK),
        .rst_n    (RESET_N),
        .scan     (SCAN),
        .rung_in  (RISE_RUNG_IN),
        .tag      (RISE_TAG),
        .rung_out (RISE_RUNG_OUT)
    );

    lce_edge_relay #(
        .FIRE_LEVEL (TAG_OFF)
    ) fall_edge_relay_inst (
        .clk      (SYS_CLK),
        .rst_n    (RESET_N),
        .scan     (SCAN),
        .rung_in  (FALL_RUNG_IN),
        .tag      (FALL_TAG),
        .rung_out (FALL_RUNG_OUT)
    );

    lce_level_coil #(
        .ON_LEVEL (TAG_ON)
    ) direct_coil_inst (
        .clk      (SYS_CLK),
        .rst_n    (RESET_N),
        .scan     (SCAN),
        .rung_in  (DIRECT_RUNG_IN),
        .rung_out (DIRECT_RUNG_OUT),
        .tag_we   (DIRECT_TAG_WE),
        .tag_wd   (DIRECT_TAG_WD)
    );

    lce_level_coil #(
        .ON_LEVEL (TAG_OFF)
    ) inverted_coil_inst (
        .clk      (SYS_CLK),
        .rst_n    (RESET_N),
        .scan     (SCAN),
        .rung_in  (INV_RUNG_IN),
        .rung_out (INV_RUNG_OUT),
        .tag_we   (INV_TAG_WE),
        .tag_wd   (INV_TAG_WD)
    );

    lce_latch_coil #(
        .ACT_RUNG    (1'h1),
        .LATCH_LEVEL (TAG_ON)
    ) latch_set_coil_inst (
        .clk      (SYS_CLK),
        .rst_n    (RESET_N),
        .scan     (SCAN),
        .rung_in  (SET_RUNG_IN),
        .tag      (SET_TAG),
        .rung_out (SET_RUNG_OUT),
        .tag_we   (SET_TAG_WE),
        .tag_wd   (SET_TAG_WD)
    );

    lce_latch_coil #(
        .ACT_RUNG    (1'h0),
        .LATCH_LEVEL (TAG_OFF)
    ) latch_clear_coil_inst (
        .clk      (SYS_CLK),
        .rst_n    (RESET_N),
        .scan     (SCAN),
        .rung_in  (CLR_RUNG_IN),
        .tag      (CLR_TAG),
        .rung_out (CLR_RUNG_OUT),
        .tag_we   (CLR_TAG_WE),
        .tag_wd   (CLR_TAG_WD)
    );

endmodule // lce_ladder_elements
`default_nettype wire

// File: lce_elem_props.sv
// Checker for the ladder element block.
// Bound to lce_ladder_elements and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module lce_elem_props (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic SCAN,
    input wire logic OPEN_RUNG_IN,
    input wire logic OPEN_TAG,
    input wire logic OPEN_RUNG_OUT,
    input wire logic CLOSED_RUNG_IN,
    input wire logic CLOSED_TAG,
    input wire logic CLOSED_RUNG_OUT,
    input wire logic RISE_RUNG_IN,
    input wire logic RISE_TAG,
    input wire logic RISE_RUNG_OUT,
    input wire logic FALL_RUNG_IN,
    input wire logic FALL_TAG,
    input wire logic FALL_RUNG_OUT,
    input wire logic DIRECT_RUNG_IN,
    input wire logic DIRECT_RUNG_OUT,
    input wire logic DIRECT_TAG_WE,
    input wire logic DIRECT_TAG_WD,
    input wire logic INV_RUNG_IN,
    input wire logic INV_RUNG_OUT,
    input wire logic INV_TAG_WE,
    input wire logic INV_TAG_WD,
    input wire logic SET_RUNG_IN,
    input wire logic SET_TAG,
    input wire logic SET_RUNG_OUT,
    input wire logic SET_TAG_WE,
    input wire logic SET_TAG_WD,
    input wire logic CLR_RUNG_IN,
    input wire logic CLR_TAG,
    input wire logic CLR_RUNG_OUT,
    input wire logic CLR_TAG_WE,
    input wire logic CLR_TAG_WD
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);
    open_pass_a: assert property (SCAN |=>
        OPEN_RUNG_OUT == ($past(OPEN_RUNG_IN) & $past(OPEN_TAG))) else $error("open");
    closed_pass_a: assert property (SCAN |=>
        CLOSED_RUNG_OUT == ($past(CLOSED_RUNG_IN) & !$past(CLOSED_TAG))) else $error("closed");
    edge_pass_a: assert property (SCAN ##1 SCAN |=>
        RISE_RUNG_OUT == ($past(RISE_RUNG_IN) & $past(RISE_TAG) & !$past(RISE_TAG, 2)) &&
        FALL_RUNG_OUT == ($past(FALL_RUNG_IN) & !$past(FALL_TAG) & $past(FALL_TAG, 2)))
        else $error("edge");
    coil_copy_a: assert property (SCAN |=>
        DIRECT_RUNG_OUT == $past(DIRECT_RUNG_IN) && INV_RUNG_OUT == $past(INV_RUNG_IN) &&
        SET_RUNG_OUT == $past(SET_RUNG_IN) && CLR_RUNG_OUT == $past(CLR_RUNG_IN))
        else $error("copy");
    direct_wr_a: assert property (SCAN |=> DIRECT_TAG_WE &&
        DIRECT_TAG_WD == $past(DIRECT_RUNG_IN)) else $error("direct");
    inv_wr_a: assert property (SCAN |=> INV_TAG_WE &&
        INV_TAG_WD != $past(INV_RUNG_IN)) else $error("inverted");
    set_wr_a: assert property (SCAN |=> SET_TAG_WE ==
        ($past(SET_RUNG_IN) & !$past(SET_TAG)) && (SET_TAG_WD || !SET_TAG_WE)) else $error("set");
    clr_wr_a: assert property (SCAN |=> CLR_TAG_WE ==
        (!$past(CLR_RUNG_IN) & $past(CLR_TAG)) && !(CLR_TAG_WD && CLR_TAG_WE)) else $error("clr");
    no_scan_a: assert property (!SCAN |=>
        !(DIRECT_TAG_WE || INV_TAG_WE || SET_TAG_WE || CLR_TAG_WE)) else $error("stray write");
endmodule // lce_elem_props
bind lce_ladder_elements lce_elem_props lce_elem_props_inst (.*);
`default_nettype wire

// File: lce_tag_mem.sv
// Tag memory model for the latching coils, with an outside agent port.
// Assumes the block's clock; writes land on the WE strobes.
`timescale 1ns/1ps
`default_nettype none
module lce_tag_mem (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic set_we,
    input  wire logic set_wd,
    input  wire logic clr_we,
    input  wire logic clr_wd,
    input  wire logic ag_we,
    input  wire logic ag_wd,
    output var  logic set_tag,
    output var  logic clr_tag
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            set_tag <= 1'h0;
            clr_tag <= 1'h0;
        end else if (ag_we) begin
            set_tag <= ag_wd;
            clr_tag <= !ag_wd;
        end else begin
            set_tag <= set_we ? set_wd : set_tag;
            clr_tag <= clr_we ? clr_wd : clr_tag;
        end
    end
endmodule // lce_tag_mem
`default_nettype wire

// File: test_ladder_contact_coil_elements.sv
// Testbench for the ladder element block with the tag memory model.
// Inputs change at the falling edge of SYS_CLK.
`timescale 1ns/1ps
`default_nettype none
module test_ladder_contact_coil_elements;
    import lce_pkg::*;
    logic SYS_CLK, RESET_N, SCAN, rg, tg, et, ag_we, ag_wd, set_tag, clr_tag, OPEN_RUNG_OUT,
        CLOSED_RUNG_OUT, RISE_RUNG_OUT, FALL_RUNG_OUT, DIRECT_RUNG_OUT, DIRECT_TAG_WE,
        DIRECT_TAG_WD, INV_RUNG_OUT, INV_TAG_WE, INV_TAG_WD, SET_RUNG_OUT, SET_TAG_WE,
        SET_TAG_WD, CLR_RUNG_OUT, CLR_TAG_WE, CLR_TAG_WD;
    int error_cnt = 0;
    int tests_run = 0;
    lce_ladder_elements lce_ladder_elements_inst (.SYS_CLK, .RESET_N, .SCAN, .OPEN_RUNG_IN(rg),
        .OPEN_TAG(tg), .OPEN_RUNG_OUT, .CLOSED_RUNG_IN(rg), .CLOSED_TAG(tg), .CLOSED_RUNG_OUT,
        .RISE_RUNG_IN(rg), .RISE_TAG(et), .RISE_RUNG_OUT, .FALL_RUNG_IN(rg), .FALL_TAG(et),
        .FALL_RUNG_OUT, .DIRECT_RUNG_IN(rg), .DIRECT_RUNG_OUT, .DIRECT_TAG_WE, .DIRECT_TAG_WD,
        .INV_RUNG_IN(rg), .INV_RUNG_OUT, .INV_TAG_WE, .INV_TAG_WD, .SET_RUNG_IN(rg),
        .SET_TAG(set_tag), .SET_RUNG_OUT, .SET_TAG_WE, .SET_TAG_WD, .CLR_RUNG_IN(rg),
        .CLR_TAG(clr_tag), .CLR_RUNG_OUT, .CLR_TAG_WE, .CLR_TAG_WD);
    lce_tag_mem lce_tag_mem_inst (.clk(SYS_CLK), .rst_n(RESET_N), .set_we(SET_TAG_WE),
        .set_wd(SET_TAG_WD), .clr_we(CLR_TAG_WE), .clr_wd(CLR_TAG_WD), .ag_we, .ag_wd,
        .set_tag, .clr_tag);
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t saw %h want %h", $time, seen, exp);
        end
    endtask
    task test_done;
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Back to back scans over tag 1 1 0 0 1 0 1 0, rung dropped for the last two edges
    task automatic t_edge;
        logic [7:0] sq = 8'h53;
        logic       p  = 1'h0;
        for (int i = 0; i < 8; i++) begin
            rg = (i < 6);
            et = sq[i];
            SCAN = 1'h1;
            @(negedge SYS_CLK);
            chk({RISE_RUNG_OUT, FALL_RUNG_OUT}, {rg & et & !p, rg & !et & p});
            p = et;
        end
        SCAN = 1'h0;
        @(negedge SYS_CLK);
    endtask
    // Contacts and direct, inverted coils over all rung and tag pairs
    task automatic t_level;
        for (int i = 0; i < 4; i++) begin
            {rg, tg} = i[1:0];
            SCAN = 1'h1;
            @(negedge SYS_CLK);
            SCAN = 1'h0;
            chk({OPEN_RUNG_OUT, CLOSED_RUNG_OUT}, {rg & tg, rg & !tg});
            chk({DIRECT_TAG_WE, DIRECT_TAG_WD, INV_TAG_WE, INV_TAG_WD}, {1'h1, rg, 1'h1, !rg});
            chk({DIRECT_RUNG_OUT, INV_RUNG_OUT, SET_RUNG_OUT, CLR_RUNG_OUT}, {4{rg}});
            @(negedge SYS_CLK);
        end
    endtask
    // Agent clears the set tag, then rung on twice and off twice
    task automatic t_latch;
        logic [7:0] ex = 8'h84;
        ag_we = 1'h1;
        @(negedge SYS_CLK);
        ag_we = 1'h0;
        for (int i = 0; i < 4; i++) begin
            rg = (i < 2);
            SCAN = 1'h1;
            @(negedge SYS_CLK);
            SCAN = 1'h0;
            chk({SET_TAG_WE & SET_TAG_WD, CLR_TAG_WE & !CLR_TAG_WD}, ex[7-2*i -: 2]);
            @(negedge SYS_CLK);
        end
        chk({set_tag, clr_tag}, 8'h02);
    endtask
    initial begin
        SYS_CLK = 1'h0;
        forever #25 SYS_CLK = ~SYS_CLK;
    end
    initial begin
        #20000;
        error_cnt++;
        test_done;
    end
    initial begin
        {RESET_N, SCAN, rg, tg, et, ag_we, ag_wd} = '0;
        repeat (6) @(negedge SYS_CLK);
        RESET_N = 1'h1;
        t_edge;
        t_level;
        t_latch;
        test_done;
    end
endmodule // test_ladder_contact_coil_elements
`default_nettype wire
